// ### common/ccls_map.vh
/*
  Constants of the coherent cache line state block: line state codes,
  state bit positions, local request codes, snoop kinds, controller states.
  Assumes it is included by its bare name from the design files.
*/
`ifndef CCLS_MAP_VH
`define CCLS_MAP_VH

// state code is {valid, unique, dirty}
`define CCLS_BIT_VALID           2
`define CCLS_BIT_UNIQUE          1
`define CCLS_BIT_DIRTY           0

`define CCLS_INVALID_STATE       3'h0
`define CCLS_SHARED_CLEAN_STATE  3'h4
`define CCLS_SHARED_DIRTY_STATE  3'h5
`define CCLS_UNIQUE_CLEAN_STATE  3'h6
`define CCLS_UNIQUE_DIRTY_STATE  3'h7

// local request codes
`define CCLS_OP_LOOKUP           3'h0
`define CCLS_OP_STORE            3'h1
`define CCLS_OP_FILL             3'h2
`define CCLS_OP_EVICT            3'h3
`define CCLS_OP_CLEAN            3'h4

// snoop kinds
`define CCLS_SNOOP_SHARE         1'h0
`define CCLS_SNOOP_INVALIDATE    1'h1

// controller states
`define CCLS_FSM_IDLE            2'h0
`define CCLS_FSM_NOTIFY          2'h1
`define CCLS_FSM_WRITEBACK       2'h2

`endif

// ### src/ccls_line_policy.v
/*
  Combinational decode of one line state: presence, store permission,
  write-back duty and the state codes a line moves to.
  Assumes a state code from the state array; no clock.
*/
`default_nettype none
`include "ccls_map.vh"

module ccls_line_policy (
  input  wire [2:0] i_state,
  output wire       o_present,
  output wire       o_dirty,
  output wire       o_silent_store,
  output wire       o_owes_wb,
  output wire [2:0] o_store_state,
  output wire [2:0] o_shared_state,
  output wire [2:0] o_clean_state
);
  // unique and dirty mean nothing without valid
  assign o_present      = i_state[`CCLS_BIT_VALID];
  assign o_dirty        = o_present & i_state[`CCLS_BIT_DIRTY];
  assign o_silent_store = o_present & i_state[`CCLS_BIT_UNIQUE];
  assign o_owes_wb      = o_dirty;
  assign o_store_state  = `CCLS_UNIQUE_DIRTY_STATE;
  assign o_shared_state = o_dirty ? `CCLS_SHARED_DIRTY_STATE
                                  : `CCLS_SHARED_CLEAN_STATE;
  assign o_clean_state  = i_state[`CCLS_BIT_UNIQUE] ? `CCLS_UNIQUE_CLEAN_STATE
                                                    : `CCLS_SHARED_CLEAN_STATE;
endmodule

`default_nettype wire

// ### src/ccls_state_array.v
/*
  Flip-flop store of one state code and one tag per line, with two
  combinational read ports and one write port.
  Assumes the caller issues at most one write per cycle.
*/
`default_nettype none
`include "ccls_map.vh"

module ccls_state_array #(
  parameter IDX_W = 4,
  parameter TAG_W = 22
) (
  input  wire             i_clk,
  input  wire             i_reset_n,
  input  wire [IDX_W-1:0] i_a_idx,
  output wire [2:0]       o_a_state,
  output wire [TAG_W-1:0] o_a_tag,
  input  wire [IDX_W-1:0] i_b_idx,
  output wire [2:0]       o_b_state,
  output wire [TAG_W-1:0] o_b_tag,
  input  wire             i_we,
  input  wire [IDX_W-1:0] i_w_idx,
  input  wire [2:0]       i_w_state,
  input  wire [TAG_W-1:0] i_w_tag
);
  localparam LINES = 1 << IDX_W;

  wire [3*LINES-1:0]     st_flat;
  wire [TAG_W*LINES-1:0] tg_flat;

  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : g_line
      localparam [IDX_W-1:0] ENTRY = g;
      reg [2:0]       st;
      reg [TAG_W-1:0] tg;
      always @(posedge i_clk) begin
        if (!i_reset_n) begin
          st <= `CCLS_INVALID_STATE;
          tg <= {TAG_W{1'b0}};
        end else if (i_we && (i_w_idx == ENTRY)) begin
          st <= i_w_state;
          tg <= i_w_tag;
        end
      end
      assign st_flat[3*g +: 3]         = st;
      assign tg_flat[TAG_W*g +: TAG_W] = tg;
    end
  endgenerate

  assign o_a_state = st_flat[3*i_a_idx +: 3];
  assign o_a_tag   = tg_flat[TAG_W*i_a_idx +: TAG_W];
  assign o_b_state = st_flat[3*i_b_idx +: 3];
  assign o_b_tag   = tg_flat[TAG_W*i_b_idx +: TAG_W];
endmodule

`default_nettype wire

// ### src/ccls_top.v
/*
  Coherency state tracking for a direct-mapped set of cache lines: local
  lookup, store, fill, evict and clean requests, and snoops from peers.
  Assumes the interconnect and requester share i_clk and hold their
  valid or acknowledge levels until the matching done pulse.
*/
// Behaviour
// - each line holds one of five states
// - invalid line counts as a miss
// - unique only when no other copy
// - dirty line owes main memory update
// - store silently to unique clean line
// - store silently to unique dirty line
// - shared clean: notify first, no write-back
// - shared dirty: notify first, owes write-back
// - never unique in two caches
// - copies in several caches are shared
// - peer fill downgrades unique to shared
// - drop clean lines without telling anyone
// - only one cache holds line dirty
// - write back before last copy leaves
// - write back while copies remain allowed
// - single copy before a store completes
// - notify other caches before changing shared
// - line is aligned block of bytes
`default_nettype none
`include "ccls_map.vh"

module ccls_top #(
  parameter ADDR_W = 32,
  parameter OFF_W  = 6,
  parameter IDX_W  = 4
) (
  input  wire              i_clk,
  input  wire              i_reset_n,
  input  wire              i_req_valid,
  input  wire [2:0]        i_req_op,
  input  wire [ADDR_W-1:0] i_req_addr,
  input  wire              i_fill_unique,
  output reg               o_req_done,
  output reg               o_req_hit,
  output reg  [2:0]        o_req_state,
  output reg               o_req_granted,
  output reg  [ADDR_W-1:0] o_line_base,
  output reg               o_notify_valid,
  input  wire              i_notify_ack,
  output reg               o_wb_valid,
  input  wire              i_wb_ack,
  output reg  [ADDR_W-1:0] o_xact_addr,
  input  wire              i_snoop_valid,
  input  wire              i_snoop_kind,
  input  wire [ADDR_W-1:0] i_snoop_addr,
  output reg               o_snoop_done,
  output reg               o_snoop_hit,
  output reg               o_snoop_pass_dirty
);
  localparam TAG_W = ADDR_W - OFF_W - IDX_W;
  function [IDX_W-1:0] f_index(input [ADDR_W-1:0] addr);
    f_index = addr[OFF_W +: IDX_W];
  endfunction
  function [TAG_W-1:0] f_tag(input [ADDR_W-1:0] addr);
    f_tag = addr[ADDR_W-1 -: TAG_W];
  endfunction
  function [ADDR_W-1:0] f_base(input [TAG_W-1:0] tag, input [IDX_W-1:0] idx);
    f_base = {tag, idx, {OFF_W{1'b0}}};
  endfunction
  reg [1:0]       fsm;
  reg [2:0]       pend_op;
  reg [IDX_W-1:0] pend_idx;
  reg [TAG_W-1:0] pend_tag;
  reg             pend_unique;
  reg [1:0]        next_fsm;
  reg [2:0]        next_pend_op;
  reg [IDX_W-1:0]  next_pend_idx;
  reg [TAG_W-1:0]  next_pend_tag;
  reg              next_pend_unique;
  reg              next_req_done;
  reg              next_req_hit;
  reg [2:0]        next_req_state;
  reg              next_req_granted;
  reg [ADDR_W-1:0] next_line_base;
  reg              next_notify_valid;
  reg              next_wb_valid;
  reg [ADDR_W-1:0] next_xact_addr;
  reg              next_snoop_done;
  reg              next_snoop_hit;
  reg              next_snoop_pass_dirty;
  reg             w_en;
  reg [IDX_W-1:0] w_idx;
  reg [2:0]       w_state;
  reg [TAG_W-1:0] w_tag;
  wire             idle    = (fsm == `CCLS_FSM_IDLE);
  wire [TAG_W-1:0] req_tag = f_tag(i_req_addr);
  wire [IDX_W-1:0] a_idx   = idle ? f_index(i_req_addr) : pend_idx;
  wire [TAG_W-1:0] a_want  = idle ? req_tag : pend_tag;
  wire [IDX_W-1:0] b_idx   = f_index(i_snoop_addr);
  wire [TAG_W-1:0] b_want  = f_tag(i_snoop_addr);
  wire [2:0]       a_state;
  wire [TAG_W-1:0] a_tag;
  wire [2:0]       b_state;
  wire [TAG_W-1:0] b_tag;
  wire             a_present;
  wire             a_silent;
  wire             a_owes_wb;
  wire [2:0]       a_store_state;
  wire [2:0]       a_clean_state;
  wire             b_present;
  wire             b_dirty;
  wire [2:0]       b_shared_state;
  // snoops always win the single write port, so a peer is never stalled
  // behind a local write-back or notification
  wire take_snoop = i_snoop_valid & ~o_snoop_done;
  wire take_req   = i_req_valid & ~o_req_done & idle & ~take_snoop;
  wire take_ack   = (fsm == `CCLS_FSM_NOTIFY) & i_notify_ack & ~take_snoop;
  wire take_wb    = (fsm == `CCLS_FSM_WRITEBACK) & i_wb_ack & ~take_snoop;
  wire a_hit = a_present & (a_tag == a_want);
  wire b_hit = b_present & (b_tag == b_want);
  wire [2:0] fill_state = i_fill_unique ? `CCLS_UNIQUE_CLEAN_STATE
                                        : `CCLS_SHARED_CLEAN_STATE;
  wire [2:0] pend_fill_state = pend_unique ? `CCLS_UNIQUE_CLEAN_STATE
                                           : `CCLS_SHARED_CLEAN_STATE;
  ccls_state_array #(.IDX_W(IDX_W), .TAG_W(TAG_W)) u_array (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_a_idx   (a_idx),
    .o_a_state (a_state),
    .o_a_tag   (a_tag),
    .i_b_idx   (b_idx),
    .o_b_state (b_state),
    .o_b_tag   (b_tag),
    .i_we      (w_en),
    .i_w_idx   (w_idx),
    .i_w_state (w_state),
    .i_w_tag   (w_tag)
  );
  ccls_line_policy u_policy_a (
    .i_state        (a_state),
    .o_present      (a_present),
    .o_dirty        (),
    .o_silent_store (a_silent),
    .o_owes_wb      (a_owes_wb),
    .o_store_state  (a_store_state),
    .o_shared_state (),
    .o_clean_state  (a_clean_state)
  );
  ccls_line_policy u_policy_b (
    .i_state        (b_state),
    .o_present      (b_present),
    .o_dirty        (b_dirty),
    .o_silent_store (),
    .o_owes_wb      (),
    .o_store_state  (),
    .o_shared_state (b_shared_state),
    .o_clean_state  ()
  );
  always @* begin
    next_fsm              = fsm;
    next_pend_op          = pend_op;
    next_pend_idx         = pend_idx;
    next_pend_tag         = pend_tag;
    next_pend_unique      = pend_unique;
    next_req_done         = 1'b0;
    next_req_hit          = o_req_hit;
    next_req_state        = o_req_state;
    next_req_granted      = o_req_granted;
    next_line_base        = o_line_base;
    next_notify_valid     = o_notify_valid;
    next_wb_valid         = o_wb_valid;
    next_xact_addr        = o_xact_addr;
    next_snoop_done       = 1'b0;
    next_snoop_hit        = o_snoop_hit;
    next_snoop_pass_dirty = o_snoop_pass_dirty;
    w_en                  = 1'b0;
    w_idx                 = a_idx;
    w_state               = a_state;
    w_tag                 = a_tag;
    if (take_snoop) begin
      next_snoop_done       = 1'b1;
      next_snoop_hit        = b_hit;
      next_snoop_pass_dirty = 1'b0;
      if (b_hit) begin
        w_en  = 1'b1;
        w_idx = b_idx;
        w_tag = b_tag;
        if (i_snoop_kind == `CCLS_SNOOP_INVALIDATE) begin
          // dirty data leaves with the snoop so memory is never orphaned
          w_state               = `CCLS_INVALID_STATE;
          next_snoop_pass_dirty = b_dirty;
        end else begin
          w_state = b_shared_state;
        end
      end
    end else if (take_req) begin
      next_req_hit     = a_hit;
      next_req_state   = a_hit ? a_state : `CCLS_INVALID_STATE;
      next_req_granted = 1'b0;
      next_line_base   = f_base(req_tag, a_idx);
      next_xact_addr   = f_base(req_tag, a_idx);
      next_pend_op     = i_req_op;
      next_pend_idx    = a_idx;
      next_pend_tag    = req_tag;
      next_pend_unique = i_fill_unique;
      case (i_req_op)
        `CCLS_OP_STORE: begin
          if (a_hit && a_silent) begin
            w_en             = 1'b1;
            w_state          = a_store_state;
            next_req_state   = a_store_state;
            next_req_granted = 1'b1;
            next_req_done    = 1'b1;
          end else if (a_hit) begin
            next_fsm          = `CCLS_FSM_NOTIFY;
            next_notify_valid = 1'b1;
          end else begin
            next_req_done = 1'b1;
          end
        end
        `CCLS_OP_FILL: begin
          if (a_hit) begin
            next_req_done = 1'b1;
          end else if (a_owes_wb) begin
            // victim must reach memory before its slot is reused
            next_fsm       = `CCLS_FSM_WRITEBACK;
            next_wb_valid  = 1'b1;
            next_xact_addr = f_base(a_tag, a_idx);
          end else begin
            w_en           = 1'b1;
            w_tag          = req_tag;
            w_state        = fill_state;
            next_req_state = fill_state;
            next_req_done  = 1'b1;
          end
        end
        `CCLS_OP_EVICT: begin
          if (a_hit && a_owes_wb) begin
            next_fsm      = `CCLS_FSM_WRITEBACK;
            next_wb_valid = 1'b1;
          end else begin
            w_en           = a_hit;
            w_state        = `CCLS_INVALID_STATE;
            next_req_state = `CCLS_INVALID_STATE;
            next_req_done  = 1'b1;
          end
        end
        `CCLS_OP_CLEAN: begin
          if (a_hit && a_owes_wb) begin
            next_fsm      = `CCLS_FSM_WRITEBACK;
            next_wb_valid = 1'b1;
          end else begin
            next_req_done = 1'b1;
          end
        end
        default: begin
          next_req_done = 1'b1;
        end
      endcase
    end else if (take_ack) begin
      next_fsm          = `CCLS_FSM_IDLE;
      next_notify_valid = 1'b0;
      next_req_done     = 1'b1;
      next_req_hit      = a_hit;
      // a snoop may have taken the line while we waited: then no store
      if (a_hit) begin
        w_en             = 1'b1;
        w_state          = a_store_state;
        next_req_state   = a_store_state;
        next_req_granted = 1'b1;
      end else begin
        next_req_state   = `CCLS_INVALID_STATE;
        next_req_granted = 1'b0;
      end
    end else if (take_wb) begin
      next_fsm      = `CCLS_FSM_IDLE;
      next_wb_valid = 1'b0;
      next_req_done = 1'b1;
      case (pend_op)
        `CCLS_OP_FILL: begin
          w_en           = 1'b1;
          w_tag          = pend_tag;
          w_state        = pend_fill_state;
          next_req_state = pend_fill_state;
        end
        `CCLS_OP_EVICT: begin
          w_en           = a_hit;
          w_state        = `CCLS_INVALID_STATE;
          next_req_state = `CCLS_INVALID_STATE;
        end
        default: begin
          w_en           = a_hit;
          w_state        = a_clean_state;
          next_req_state = a_hit ? a_clean_state : `CCLS_INVALID_STATE;
        end
      endcase
    end
  end
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      fsm                <= `CCLS_FSM_IDLE;
      pend_op            <= `CCLS_OP_LOOKUP;
      pend_idx           <= {IDX_W{1'b0}};
      pend_tag           <= {TAG_W{1'b0}};
      pend_unique        <= 1'b0;
      o_req_done         <= 1'b0;
      o_req_hit          <= 1'b0;
      o_req_state        <= `CCLS_INVALID_STATE;
      o_req_granted      <= 1'b0;
      o_line_base        <= {ADDR_W{1'b0}};
      o_notify_valid     <= 1'b0;
      o_wb_valid         <= 1'b0;
      o_xact_addr        <= {ADDR_W{1'b0}};
      o_snoop_done       <= 1'b0;
      o_snoop_hit        <= 1'b0;
      o_snoop_pass_dirty <= 1'b0;
    end else begin
      fsm                <= next_fsm;
      pend_op            <= next_pend_op;
      pend_idx           <= next_pend_idx;
      pend_tag           <= next_pend_tag;
      pend_unique        <= next_pend_unique;
      o_req_done         <= next_req_done;
      o_req_hit          <= next_req_hit;
      o_req_state        <= next_req_state;
      o_req_granted      <= next_req_granted;
      o_line_base        <= next_line_base;
      o_notify_valid     <= next_notify_valid;
      o_wb_valid         <= next_wb_valid;
      o_xact_addr        <= next_xact_addr;
      o_snoop_done       <= next_snoop_done;
      o_snoop_hit        <= next_snoop_hit;
      o_snoop_pass_dirty <= next_snoop_pass_dirty;
    end
  end
endmodule

`default_nettype wire

// ### test/ccls_fabric_model.sv
/*
  interconnect model: acknowledges notify and write-back requests.
  assumes the block's clock; the bench sets the lag before each request.
*/
`default_nettype none
module ccls_fabric_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_notify_valid,
  input  wire logic       i_wb_valid,
  input  wire logic       i_req_done,
  input  wire logic [1:0] i_lag,
  output var  logic       o_notify_ack,
  output var  logic       o_wb_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt;
  // ack held until done: the block may see it late behind a snoop
  always @(posedge i_clk) begin
    if (!i_reset_n || i_req_done) begin
      o_notify_ack <= 1'b0;
      o_wb_ack <= 1'b0;
      cnt <= 2'h0;
    end else if ((i_notify_valid || i_wb_valid) && !o_notify_ack && !o_wb_ack) begin
      cnt <= cnt + 2'h1;
      if (cnt == i_lag) begin
        o_notify_ack <= i_notify_valid;
        o_wb_ack <= i_wb_valid;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/ccls_top_monitor.sv
/*
  checker of the line state block, watching its ports only.
  assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
`include "ccls_map.vh"
module ccls_top_monitor #(
  parameter ADDR_W = 32,
  parameter OFF_W  = 6
) (
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  input wire logic [2:0]        i_req_op,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic              o_req_done,
  input wire logic              o_req_hit,
  input wire logic [2:0]        o_req_state,
  input wire logic              o_req_granted,
  input wire logic [ADDR_W-1:0] o_line_base,
  input wire logic              o_notify_valid,
  input wire logic              i_notify_ack,
  input wire logic              o_wb_valid,
  input wire logic              i_wb_ack,
  input wire logic [ADDR_W-1:0] o_xact_addr,
  input wire logic              i_snoop_valid,
  input wire logic              o_snoop_done,
  input wire logic              o_snoop_hit,
  input wire logic              o_snoop_pass_dirty
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // past address: the requester may drop its request inside the done cycle
  line_base_a: assert property (o_req_done |->
    o_line_base == {$past(i_req_addr[ADDR_W-1:OFF_W]), {OFF_W{1'b0}}})
    else $error("line base not aligned request address");
  legal_state_a: assert property (o_req_done |-> !(o_req_state inside {3'h1, 3'h2, 3'h3}))
    else $error("illegal line state reported");
  lookup_miss_a: assert property (o_req_done && !o_req_hit
    && $past(i_req_op) == `CCLS_OP_LOOKUP |-> o_req_state == `CCLS_INVALID_STATE)
    else $error("miss reported with a valid state");
  grant_unique_a: assert property (o_req_done && o_req_granted
    |-> o_req_state == `CCLS_UNIQUE_DIRTY_STATE)
    else $error("store granted without unique dirty line");
  notify_hold_a: assert property (o_notify_valid && !i_notify_ack |=> o_notify_valid)
    else $error("notify dropped before ack");
  notify_done_a: assert property (o_notify_valid && i_notify_ack && !i_snoop_valid
    |=> o_req_done && !o_notify_valid)
    else $error("store not completed after ack");
  wb_hold_a: assert property (o_wb_valid && !i_wb_ack
    |=> o_wb_valid && $stable(o_xact_addr))
    else $error("write-back dropped or moved before ack");
  xact_align_a: assert property (o_notify_valid || o_wb_valid
    |-> o_xact_addr[OFF_W-1:0] == '0)
    else $error("transaction address not line aligned");
  snoop_answer_a: assert property (i_snoop_valid && !o_snoop_done |=> o_snoop_done)
    else $error("snoop not answered in one cycle");
  pass_dirty_a: assert property (o_snoop_done && o_snoop_pass_dirty |-> o_snoop_hit)
    else $error("dirty duty passed on a snoop miss");
  reset_quiet_a: assert property (disable iff (1'b0) !i_reset_n |=> !o_req_done
    && !o_notify_valid && !o_wb_valid && o_req_state == `CCLS_INVALID_STATE)
    else $error("outputs active after reset");
  cover property (o_notify_valid && i_notify_ack);
  cover property (o_wb_valid && i_wb_ack);
  cover property (o_snoop_done && o_snoop_pass_dirty);
endmodule
bind ccls_top ccls_top_monitor #(.ADDR_W(ADDR_W), .OFF_W(OFF_W)) u_mon (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_op(i_req_op), .i_req_addr(i_req_addr),
  .o_req_done(o_req_done), .o_req_hit(o_req_hit), .o_req_state(o_req_state),
  .o_req_granted(o_req_granted), .o_line_base(o_line_base),
  .o_notify_valid(o_notify_valid), .i_notify_ack(i_notify_ack), .o_wb_valid(o_wb_valid),
  .i_wb_ack(i_wb_ack), .o_xact_addr(o_xact_addr), .i_snoop_valid(i_snoop_valid),
  .o_snoop_done(o_snoop_done), .o_snoop_hit(o_snoop_hit),
  .o_snoop_pass_dirty(o_snoop_pass_dirty));
`default_nettype wire

// ### test/tb.sv
/*
  self-checking bench of the line state block with the fabric model.
  assumes ccls_top defaults: 32-bit address, 64-byte line, 16 lines.
*/
`default_nettype none
`include "ccls_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam AW = 32;
  localparam logic [2:0] INV = `CCLS_INVALID_STATE;
  localparam logic [2:0] UCLN = `CCLS_UNIQUE_CLEAN_STATE;
  localparam logic [2:0] UDTY = `CCLS_UNIQUE_DIRTY_STATE;
  localparam logic [2:0] SCLN = `CCLS_SHARED_CLEAN_STATE;
  localparam logic [2:0] SDTY = `CCLS_SHARED_DIRTY_STATE;
  logic i_clk = 1'b0, i_reset_n = 1'b0, rv = 1'b0, fu = 1'b0, sv = 1'b0, sk = 1'b0;
  logic [2:0] op = 3'h0;
  logic [AW-1:0] ra = '0, sa = '0, a, b, c;
  logic [1:0] lag = 2'h0;
  wire done, hit, gr, nv, na, wv, wa, sd, sh, spd;
  wire [2:0] st;
  wire [AW-1:0] lb, xa;
  integer seed = 46044;
  integer fail_count = 0;
  integer checked = 0;
  logic [AW+4:0] req_q[$];
  logic [1:0] snp_q[$];
  always #5 i_clk = ~i_clk;
  ccls_top DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(rv), .i_req_op(op),
    .i_req_addr(ra), .i_fill_unique(fu), .o_req_done(done), .o_req_hit(hit),
    .o_req_state(st), .o_req_granted(gr), .o_line_base(lb), .o_notify_valid(nv),
    .i_notify_ack(na), .o_wb_valid(wv), .i_wb_ack(wa), .o_xact_addr(xa),
    .i_snoop_valid(sv), .i_snoop_kind(sk), .i_snoop_addr(sa), .o_snoop_done(sd),
    .o_snoop_hit(sh), .o_snoop_pass_dirty(spd));
  ccls_fabric_model u_fab (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_notify_valid(nv),
    .i_wb_valid(wv), .i_req_done(done), .i_lag(lag), .o_notify_ack(na), .o_wb_ack(wa));
  task automatic stop_test;
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp_req(input logic [AW+4:0] got, input logic [AW+4:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_snp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // results are read at the falling edge, well clear of the register updates
  always @(negedge i_clk) begin
    if (done === 1'b1)
      cmp_req({hit, st, gr, lb}, req_q.size() > 0 ? req_q.pop_front() : 'x);
    if (sd === 1'b1)
      cmp_snp({sh, spd}, snp_q.size() > 0 ? snp_q.pop_front() : 2'bxx);
  end
  function automatic logic [AW-1:0] mk(input logic [3:0] i);
    logic [AW-1:0] r;
    r = $random(seed);
    return {r[31:10], i, r[5:0]};
  endfunction
  task automatic req(input logic [2:0] o, input logic [AW-1:0] x, input logic u,
                     input logic h, input logic [2:0] s, input logic g);
    integer n;
    @(negedge i_clk);
    req_q.push_back({h, s, g, x[AW-1:6], 6'h00});
    lag = 2'($random(seed));
    rv = 1'b1;
    op = o;
    ra = x;
    fu = u;
    for (n = 0; n < 50 && done !== 1'b1; n++) @(negedge i_clk);
    if (n == 50) begin
      fail_count++;
      stop_test();
    end
    rv = 1'b0;
    ra = ~ra;
  endtask
  task automatic snp(input logic k, input logic [AW-1:0] x, input logic h, input logic p);
    integer n;
    @(negedge i_clk);
    snp_q.push_back({h, p});
    sv = 1'b1;
    sk = k;
    sa = x;
    for (n = 0; n < 50 && sd !== 1'b1; n++) @(negedge i_clk);
    if (n == 50) begin
      fail_count++;
      stop_test();
    end
    sv = 1'b0;
    sa = ~sa;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    @(negedge i_clk) i_reset_n = 1'b1;
    // every code on an absent line; fill skipped, codes above clean act as lookup
    for (int i = 0; i < 8; i++)
      if (i != 2) req(3'(i), mk(4'hf), 1'b0, 1'b0, INV, 1'b0);
    a = mk(4'h1);
    req(`CCLS_OP_FILL, a, 1'b1, 1'b0, UCLN, 1'b0);
    req(`CCLS_OP_STORE, a, 1'b0, 1'b1, UDTY, 1'b1);
    req(`CCLS_OP_STORE, a, 1'b0, 1'b1, UDTY, 1'b1);
    snp(`CCLS_SNOOP_SHARE, a, 1'b1, 1'b0);
    req(`CCLS_OP_LOOKUP, a, 1'b0, 1'b1, SDTY, 1'b0);
    req(`CCLS_OP_CLEAN, a, 1'b0, 1'b1, SCLN, 1'b0);
    req(`CCLS_OP_STORE, a, 1'b0, 1'b1, UDTY, 1'b1);
    snp(`CCLS_SNOOP_SHARE, a, 1'b1, 1'b0);
    req(`CCLS_OP_STORE, a, 1'b0, 1'b1, UDTY, 1'b1);
    req(`CCLS_OP_EVICT, a, 1'b0, 1'b1, INV, 1'b0);
    req(`CCLS_OP_LOOKUP, a, 1'b0, 1'b0, INV, 1'b0);
    b = mk(4'h2);
    req(`CCLS_OP_FILL, b, 1'b0, 1'b0, SCLN, 1'b0);
    req(`CCLS_OP_EVICT, b, 1'b0, 1'b1, INV, 1'b0);
    snp(`CCLS_SNOOP_INVALIDATE, b, 1'b0, 1'b0);
    req(`CCLS_OP_FILL, b, 1'b0, 1'b0, SCLN, 1'b0);
    // notify wait loses the line to an invalidate: no grant afterwards
    fork
      req(`CCLS_OP_STORE, b, 1'b0, 1'b0, INV, 1'b0);
      begin
        repeat (2) @(negedge i_clk);
        snp(`CCLS_SNOOP_INVALIDATE, b, 1'b1, 1'b0);
      end
    join
    req(`CCLS_OP_FILL, b, 1'b0, 1'b0, SCLN, 1'b0);
    req(`CCLS_OP_STORE, b, 1'b0, 1'b1, UDTY, 1'b1);
    cmp_req({5'h00, xa}, {5'h00, b[31:6], 6'h00});
    snp(`CCLS_SNOOP_INVALIDATE, b, 1'b1, 1'b1);
    req(`CCLS_OP_LOOKUP, b, 1'b0, 1'b0, INV, 1'b0);
    c = mk(4'h3);
    req(`CCLS_OP_FILL, c, 1'b1, 1'b0, UCLN, 1'b0);
    req(`CCLS_OP_STORE, c, 1'b0, 1'b1, UDTY, 1'b1);
    req(`CCLS_OP_FILL, {~c[31:10], c[9:0]}, 1'b0, 1'b0, SCLN, 1'b0);
    cmp_req({5'h00, xa}, {5'h00, c[31:6], 6'h00});
    req(`CCLS_OP_FILL, {~c[31:10], c[9:0]}, 1'b1, 1'b1, SCLN, 1'b0);
    req(`CCLS_OP_LOOKUP, c, 1'b0, 1'b0, INV, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
